// *** common/mbc_pkg.sv ***
// constants, field layouts and types of the modbus counter/watchdog handler
// assumes a 40 MHz system clock and a byte-level rtu link layer outside
package mbc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 100_000_000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int NUM_CH        = 8;
  localparam int RX_DEPTH      = 10;

  localparam logic [7:0] FC_READ_BITS  = 8'h01;
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_CLEAR_MANY = 8'h0F;
  localparam logic [7:0] EXC_FLAG      = 8'h80;
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_FUNC      = 8'h01;
  localparam logic [7:0] EXC_ADDR      = 8'h02;
  localparam logic [7:0] EXC_VALUE     = 8'h03;

  localparam logic [15:0] A_COUNT_LAST   = 16'h0007;
  localparam logic [15:0] A_WD_ENABLE    = 16'h0104;
  localparam logic [15:0] A_LATCH_CLEAR  = 16'h0107;
  localparam logic [15:0] A_WD_FLAG      = 16'h010D;
  localparam logic [15:0] A_WD_PERIOD    = 16'h01E8;
  localparam logic [15:0] A_CNT_CLEAR    = 16'h0200;
  localparam logic [15:0] A_MULTI_LAST   = 16'h0207;
  localparam logic [15:0] A_CNT_LAST     = 16'h020D;
  localparam logic [15:0] A_HOST_ALIVE   = 16'h3038;
  localparam logic [15:0] COIL_ON        = 16'hFF00;
  localparam logic [15:0] COIL_OFF       = 16'h0000;
  localparam logic [15:0] ALIVE_DATA     = 16'h0000;
  localparam logic [15:0] QTY_ONE        = 16'h0001;
  localparam logic [15:0] QTY_READ_MAX   = 16'h0008;
  localparam logic [15:0] QTY_CLEAR_MAX  = 16'h000E;
  localparam logic [16:0] CH_END_MAX     = 17'h0_0008;
  localparam logic [7:0]  BYTE_COUNT_ONE = 8'h01;
  localparam logic [7:0]  SLAVE_MIN      = 8'h01;
  localparam logic [7:0]  SLAVE_MAX      = 8'hF7;

  localparam logic [3:0] LEN_MIN   = 4'h4;
  localparam logic [3:0] LEN_STD   = 4'h8;
  localparam logic [3:0] LEN_MULTI = 4'hA;
  localparam logic [4:0] RSP_NONE  = 5'h00;
  localparam logic [4:0] RSP_EXC   = 5'h03;
  localparam logic [4:0] RSP_HEAD  = 5'h03;
  localparam logic [4:0] RSP_BIT   = 5'h04;
  localparam logic [4:0] RSP_REG   = 5'h05;
  localparam logic [4:0] RSP_ECHO  = 5'h06;
  localparam logic [7:0] BC_BIT    = 8'h01;
  localparam logic [7:0] BC_REG    = 8'h02;

  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;

  typedef struct packed {
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
    logic [7:0]  count;
    logic [7:0]  mask;
  } mbc_req_t;

  typedef enum logic [2:0] {S_RX = 3'h1, S_EXEC = 3'h2, S_TX = 3'h4} mbc_state_t;

  typedef enum logic [5:0] {
    K_NONE = 6'h01, K_CNT = 6'h02, K_BIT = 6'h04,
    K_REG  = 6'h08, K_ECHO = 6'h10, K_EXC = 6'h20
  } mbc_kind_t;
endpackage

// *** hw/mbc_crc16.sv ***
// one-byte step of the rtu crc, purely combinational
// assumes the caller holds the running value in its own register
module mbc_crc16 #(
  parameter logic [15:0] POLY = mbc_pkg::CRC_POLY
) (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule

// *** hw/mbc_handler.sv ***
// modbus rtu command handler: counter reads, counter and latch clears, host watchdog
// assumes a byte stream from a uart with frame-end detection; tx bytes are paced by TX_READY
module mbc_handler #(
  parameter int TICK_CYCLES = mbc_pkg::TICK_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [7:0] MODULE_ADDR,
  input  wire logic [7:0] EVENT_IN,
  input  wire logic [7:0] TIMEOUT_VALUE,
  input  wire logic       NV_STATUS_IN,
  input  wire logic       RX_VALID,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_FRAME_END,
  input  wire logic       TX_READY,
  output logic            TX_VALID,
  output logic      [7:0] TX_DATA,
  output logic            LATCH_CLEAR,
  output logic            WATCHDOG_ENABLED,
  output logic            TIMEOUT_STATUS,
  output logic            LED_FLASH
);
  localparam int NCH = mbc_pkg::NUM_CH;

  mbc_pkg::mbc_state_t state_reg;
  mbc_pkg::mbc_kind_t  rsp_kind_reg;
  mbc_pkg::mbc_kind_t  dec_kind;
  mbc_pkg::mbc_req_t   req;
  logic [7:0]  rx_buf [mbc_pkg::RX_DEPTH];
  logic [3:0]  rx_len_reg;
  logic        rx_over_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] rx_crc_upd;
  logic [15:0] tx_crc_reg;
  logic [15:0] tx_crc_upd;
  logic [7:0]  tx_data_reg;
  logic        tx_valid_reg;
  logic [4:0]  tx_idx_reg;
  logic [4:0]  rsp_len_reg;
  logic [7:0]  exc_code_reg;
  logic        rsp_flag_reg;
  logic [7:0]  rsp_period_reg;
  logic [15:0] cnt_reg  [NCH];
  logic [15:0] snap_reg [NCH];
  logic        wd_en_reg;
  logic        flag_reg;
  logic        led_reg;
  logic        latch_reg;
  logic        restore_done_reg;
  logic [31:0] tick_reg;
  logic [7:0]  elapsed_reg;

  assign req = {rx_buf[0], rx_buf[1], rx_buf[2], rx_buf[3],
                rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7]};

  mbc_crc16 u_rx_crc (.crc_in(rx_crc_reg), .data_in(RX_DATA), .crc_out(rx_crc_upd));
  mbc_crc16 u_tx_crc (.crc_in(tx_crc_reg), .data_in(tx_data_reg), .crc_out(tx_crc_upd));

  wire in_rx   = state_reg == mbc_pkg::S_RX;
  wire in_exec = state_reg == mbc_pkg::S_EXEC;
  wire in_tx   = state_reg == mbc_pkg::S_TX;

  // crc over frame plus its own crc bytes leaves a zero residue
  wire slave_ok = MODULE_ADDR >= mbc_pkg::SLAVE_MIN && MODULE_ADDR <= mbc_pkg::SLAVE_MAX;
  wire frame_ok = in_rx & RX_FRAME_END & !rx_over_reg & (rx_len_reg >= mbc_pkg::LEN_MIN)
                & (rx_buf[0] == MODULE_ADDR) & slave_ok
                & (rx_crc_reg == mbc_pkg::CRC_RESIDUE);

  wire f01 = req.func == mbc_pkg::FC_READ_BITS;
  wire f03 = req.func == mbc_pkg::FC_READ_HOLD;
  wire f04 = req.func == mbc_pkg::FC_READ_INPUT;
  wire f05 = req.func == mbc_pkg::FC_WRITE_COIL;
  wire f0f = req.func == mbc_pkg::FC_CLEAR_MANY;

  wire [16:0] rd_end  = {1'b0, req.addr} + {1'b0, req.data};
  wire qty_rd_ok  = req.data >= mbc_pkg::QTY_ONE && req.data <= mbc_pkg::QTY_READ_MAX
                  && rd_end <= mbc_pkg::CH_END_MAX;
  wire cnt_addr   = req.addr >= mbc_pkg::A_CNT_CLEAR && req.addr <= mbc_pkg::A_CNT_LAST;
  wire multi_addr = req.addr >= mbc_pkg::A_CNT_CLEAR && req.addr <= mbc_pkg::A_MULTI_LAST;
  wire a05 = req.addr == mbc_pkg::A_WD_ENABLE || req.addr == mbc_pkg::A_LATCH_CLEAR
          || req.addr == mbc_pkg::A_WD_FLAG || cnt_addr;
  wire v_one = req.data == mbc_pkg::QTY_ONE;
  wire v05 = req.data == mbc_pkg::COIL_ON
          || (req.addr == mbc_pkg::A_WD_ENABLE && req.data == mbc_pkg::COIL_OFF);
  wire v0f = req.data >= mbc_pkg::QTY_ONE && req.data <= mbc_pkg::QTY_CLEAR_MAX
          && req.count == mbc_pkg::BYTE_COUNT_ONE;
  wire known  = f01 | f03 | f04 | f05 | f0f;
  wire len_ok = f0f ? rx_len_reg == mbc_pkg::LEN_MULTI : rx_len_reg == mbc_pkg::LEN_STD;
  wire a_ok = (f01 & (req.addr == mbc_pkg::A_WD_FLAG)) | (f03 & (req.addr == mbc_pkg::A_WD_PERIOD))
            | (f04 & (req.addr <= mbc_pkg::A_COUNT_LAST)) | (f05 & a05) | (f0f & multi_addr);
  wire v_ok = (f01 & v_one) | (f03 & v_one) | (f04 & qty_rd_ok) | (f05 & v05) | (f0f & v0f);

  wire dec_alive = (f03 | f04) & len_ok & req.addr == mbc_pkg::A_HOST_ALIVE
                 & req.data == mbc_pkg::ALIVE_DATA;
  wire [7:0] dec_code = !known  ? mbc_pkg::EXC_FUNC  :
                        !len_ok ? mbc_pkg::EXC_VALUE :
                        !a_ok   ? mbc_pkg::EXC_ADDR  :
                        !v_ok   ? mbc_pkg::EXC_VALUE : mbc_pkg::EXC_NONE;
  assign dec_kind = dec_alive ? mbc_pkg::K_NONE :
                    dec_code != mbc_pkg::EXC_NONE ? mbc_pkg::K_EXC :
                    f04 ? mbc_pkg::K_CNT : f01 ? mbc_pkg::K_BIT :
                    f03 ? mbc_pkg::K_REG : mbc_pkg::K_ECHO;
  wire [4:0] dec_len = dec_kind == mbc_pkg::K_NONE ? mbc_pkg::RSP_NONE :
                       dec_kind == mbc_pkg::K_EXC  ? mbc_pkg::RSP_EXC  :
                       dec_kind == mbc_pkg::K_CNT  ? mbc_pkg::RSP_HEAD + {req.data[3:0], 1'b0} :
                       dec_kind == mbc_pkg::K_BIT  ? mbc_pkg::RSP_BIT  :
                       dec_kind == mbc_pkg::K_REG  ? mbc_pkg::RSP_REG  : mbc_pkg::RSP_ECHO;

  wire ok_cmd      = in_exec & (dec_kind == mbc_pkg::K_ECHO);
  wire do_wd       = ok_cmd & f05 & (req.addr == mbc_pkg::A_WD_ENABLE);
  wire do_latch    = ok_cmd & f05 & (req.addr == mbc_pkg::A_LATCH_CLEAR);
  wire do_flag_clr = ok_cmd & f05 & (req.addr == mbc_pkg::A_WD_FLAG);
  // 0x0208..0x020D name no fitted channel: acknowledged, nothing to clear
  wire do_clr_one  = ok_cmd & f05 & cnt_addr & !req.addr[3];
  wire do_multi    = ok_cmd & f0f;
  wire [7:0] qty_mask = req.data >= mbc_pkg::QTY_READ_MAX ? 8'hFF :
                        8'((8'h01 << req.data[2:0]) - 8'h01);
  wire [7:0] clr_one  = do_clr_one ? 8'(8'h01 << req.addr[2:0]) : 8'h00;
  wire [7:0] clr_many = do_multi ? 8'((req.mask & qty_mask) << req.addr[2:0]) : 8'h00;
  wire [7:0] clr_vec  = clr_one | clr_many;

  wire is_exc  = rsp_kind_reg == mbc_pkg::K_EXC;
  wire is_echo = rsp_kind_reg == mbc_pkg::K_ECHO;
  wire is_cnt  = rsp_kind_reg == mbc_pkg::K_CNT;
  wire is_bit  = rsp_kind_reg == mbc_pkg::K_BIT;
  wire [4:0] tx_nidx = tx_idx_reg + 5'h01;
  wire [4:0] sel     = in_exec ? 5'h00 : tx_nidx;
  wire [4:0] cnt_off = sel - mbc_pkg::RSP_HEAD;
  wire [2:0] cnt_ch  = req.addr[2:0] + cnt_off[3:1];
  wire [15:0] cnt_word = snap_reg[cnt_ch];
  wire [7:0] cnt_byte  = cnt_off[0] ? cnt_word[7:0] : cnt_word[15:8];
  wire [7:0] count_byte = is_cnt ? {3'h0, req.data[3:0], 1'b0} :
                          is_bit ? mbc_pkg::BC_BIT : mbc_pkg::BC_REG;
  wire [7:0] data_byte  = is_cnt ? cnt_byte : is_bit ? {7'h00, rsp_flag_reg} :
                          (sel == mbc_pkg::RSP_HEAD ? 8'h00 : rsp_period_reg);
  wire [7:0] body_byte  = sel == 5'h00 ? rx_buf[0] :
                          sel == 5'h01 ? (is_exc ? req.func | mbc_pkg::EXC_FLAG : req.func) :
                          is_exc  ? exc_code_reg :
                          is_echo ? rx_buf[sel[3:0]] :
                          sel == 5'h02 ? count_byte : data_byte;
  wire tx_fire = tx_valid_reg & TX_READY;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg      <= mbc_pkg::S_RX;
      rsp_kind_reg   <= mbc_pkg::K_NONE;
      tx_valid_reg   <= 1'b0;
      tx_data_reg    <= 8'h00;
      tx_idx_reg     <= 5'h00;
      tx_crc_reg     <= mbc_pkg::CRC_INIT;
      rsp_len_reg    <= 5'h00;
      exc_code_reg   <= 8'h00;
      rsp_flag_reg   <= 1'b0;
      rsp_period_reg <= 8'h00;
    end else begin
      case (state_reg)
        mbc_pkg::S_RX: begin
          if (frame_ok) state_reg <= mbc_pkg::S_EXEC;
        end
        mbc_pkg::S_EXEC: begin
          rsp_kind_reg   <= dec_kind;
          rsp_len_reg    <= dec_len;
          exc_code_reg   <= dec_code;
          rsp_flag_reg   <= flag_reg;
          rsp_period_reg <= TIMEOUT_VALUE;
          tx_idx_reg     <= 5'h00;
          tx_crc_reg     <= mbc_pkg::CRC_INIT;
          tx_data_reg    <= body_byte;
          if (dec_kind == mbc_pkg::K_NONE) begin
            state_reg <= mbc_pkg::S_RX;
          end else begin
            tx_valid_reg <= 1'b1;
            state_reg    <= mbc_pkg::S_TX;
          end
        end
        mbc_pkg::S_TX: begin
          if (tx_fire) begin
            if (tx_idx_reg < rsp_len_reg) tx_crc_reg <= tx_crc_upd;
            tx_idx_reg <= tx_nidx;
            if (tx_nidx < rsp_len_reg) begin
              tx_data_reg <= body_byte;
            end else if (tx_nidx == rsp_len_reg) begin
              tx_data_reg <= tx_crc_upd[7:0];
            end else if (tx_nidx == rsp_len_reg + 5'h01) begin
              tx_data_reg <= tx_crc_reg[15:8];
            end else begin
              tx_valid_reg <= 1'b0;
              state_reg    <= mbc_pkg::S_RX;
            end
          end
        end
        default: state_reg <= mbc_pkg::S_RX;
      endcase
    end
  end

  // half duplex: bytes arriving while a reply is built or sent are dropped
  wire rx_restart = in_exec | in_tx | (in_rx & RX_FRAME_END & !frame_ok);
  wire rx_take    = in_rx & RX_VALID & !RX_FRAME_END;
  wire rx_room    = rx_len_reg < mbc_pkg::LEN_MULTI;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_len_reg  <= 4'h0;
      rx_over_reg <= 1'b0;
      rx_crc_reg  <= mbc_pkg::CRC_INIT;
    end else if (rx_restart) begin
      rx_len_reg  <= 4'h0;
      rx_over_reg <= 1'b0;
      rx_crc_reg  <= mbc_pkg::CRC_INIT;
    end else if (rx_take) begin
      if (rx_room) begin
        rx_len_reg <= rx_len_reg + 4'h1;
        rx_crc_reg <= rx_crc_upd;
      end else begin
        rx_over_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rx_take && rx_room) rx_buf[rx_len_reg] <= RX_DATA;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i]  <= 16'h0000;
        snap_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // an event in the clearing cycle is kept as the first count
        if (clr_vec[i]) cnt_reg[i] <= {15'h0000, EVENT_IN[i]};
        else if (EVENT_IN[i] && cnt_reg[i] != mbc_pkg::CNT_MAX) cnt_reg[i] <= cnt_reg[i] + 16'h0001;
        if (in_exec) snap_reg[i] <= cnt_reg[i];
      end
    end
  end

  wire alive_hit  = in_exec & dec_alive;
  wire tick_done  = tick_reg == 32'(TICK_CYCLES - 1);
  wire wd_restart = alive_hit | !wd_en_reg | do_wd;
  // a timeout value of zero never expires
  wire expire  = wd_en_reg & (TIMEOUT_VALUE != 8'h00) & (elapsed_reg >= TIMEOUT_VALUE);
  wire nv_load = !restore_done_reg & NV_STATUS_IN;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_reg         <= 32'h0000_0000;
      elapsed_reg      <= 8'h00;
      wd_en_reg        <= 1'b0;
      flag_reg         <= 1'b0;
      led_reg          <= 1'b0;
      latch_reg        <= 1'b0;
      restore_done_reg <= 1'b0;
    end else begin
      tick_reg <= (alive_hit | tick_done) ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      if (wd_restart) elapsed_reg <= 8'h00;
      else if (tick_done && elapsed_reg != 8'hFF) elapsed_reg <= elapsed_reg + 8'h01;
      if (do_wd) wd_en_reg <= req.data == mbc_pkg::COIL_ON;
      if (expire | nv_load) flag_reg <= 1'b1;
      else if (do_flag_clr) flag_reg <= 1'b0;
      led_reg          <= flag_reg & (tick_done ? !led_reg : led_reg);
      latch_reg        <= do_latch;
      restore_done_reg <= 1'b1;
    end
  end

  assign TX_VALID         = tx_valid_reg;
  assign TX_DATA          = tx_data_reg;
  assign LATCH_CLEAR      = latch_reg;
  assign WATCHDOG_ENABLED = wd_en_reg;
  assign TIMEOUT_STATUS   = flag_reg;
  assign LED_FLASH        = led_reg;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence exec_cnt_s;  in_exec && dec_kind == mbc_pkg::K_CNT;  endsequence
  sequence exec_echo_s; in_exec && dec_kind == mbc_pkg::K_ECHO; endsequence

  rd_start_a: assert property (in_tx && is_cnt && tx_idx_reg == 5'h03
    |-> tx_data_reg == snap_reg[req.addr[2:0]][15:8])
    else $error("counter reply starts at wrong channel");
  cnt_len_a: assert property (exec_cnt_s |=> rsp_len_reg == 5'h03 + {req.data[3:0], 1'b0})
    else $error("counter reply length wrong");
  exc_func_a: assert property (in_tx && is_exc && tx_idx_reg == 5'h01 |-> tx_data_reg[7])
    else $error("exception function lacks top bit");
  clear_one_a: assert property (exec_echo_s and (f05 && cnt_addr && req.addr[3:0] == 4'h0)
    |=> cnt_reg[0] <= 16'h0001)
    else $error("single clear missed");
  latch_pulse_a: assert property (latch_reg |-> $past(in_exec) && req.addr == 16'h0107)
    else $error("latch clear without command");
  echo_bytes_a: assert property (in_tx && is_echo && tx_idx_reg >= 5'h02
    && tx_idx_reg <= 5'h05 |-> tx_data_reg == rx_buf[tx_idx_reg[3:0]])
    else $error("echo byte differs");
  multi_clear_a: assert property (exec_echo_s and
    (f0f && req.mask[0] && req.addr[2:0] == 3'h0) |=> cnt_reg[0] <= 16'h0001)
    else $error("masked clear missed");
  bit_reply_a: assert property (in_tx && is_bit && tx_idx_reg == 5'h03
    |-> tx_data_reg == {7'h00, rsp_flag_reg})
    else $error("status byte wrong");
  reg_reply_a: assert property (in_tx && rsp_kind_reg == mbc_pkg::K_REG
    && tx_idx_reg == 5'h04 |-> tx_data_reg == rsp_period_reg)
    else $error("timeout value byte wrong");
  alive_quiet_a: assert property (in_exec && dec_alive |=> (in_rx && !tx_valid_reg) [*2])
    else $error("host alive answered");
  wd_enable_a: assert property (exec_echo_s and (f05 && req.addr == 16'h0104)
    |=> wd_en_reg == (req.data == 16'hFF00))
    else $error("watchdog enable not taken");
  flag_clear_a: assert property (do_flag_clr && !expire && restore_done_reg |=> !flag_reg)
    else $error("status clear missed");
  wd_expire_a: assert property (expire |=> flag_reg ##1 flag_reg)
    else $error("expiry not latched");
  flag_sticky_a: assert property (flag_reg && !do_flag_clr |=> flag_reg)
    else $error("status dropped without clear");
  addr_filter_a: assert property (in_rx && RX_FRAME_END && rx_buf[0] != MODULE_ADDR |=> in_rx)
    else $error("foreign frame handled");
  exc_unknown_a: assert property (in_exec && !known |=> is_exc && exc_code_reg == 8'h01)
    else $error("unknown function not refused");
endmodule

// *** tb/mbc_master.sv ***
// modbus rtu master model driving the handler's byte link
// assumes the bench calls xfer hierarchically, one frame at a time
module mbc_master (
  input  wire logic       CLOCK,
  output logic            RX_VALID,
  output logic      [7:0] RX_DATA,
  output logic            RX_FRAME_END,
  output logic            TX_READY,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slow = 1'b0;
  logic [7:0] rsp[$];
  logic       crc_ok;
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    RX_FRAME_END = 1'b0;
    TX_READY = 1'b1;
  end
  // slow mode holds TX_READY low every other cycle
  always @(posedge CLOCK) begin
    #1;
    TX_READY = slow ? ~TX_READY : 1'b1;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  task automatic put(input logic [7:0] b);
    @(posedge CLOCK);
    #1;
    RX_VALID = 1'b1;
    RX_DATA = b;
  endtask
  task automatic xfer(input logic [7:0] sa, input logic [79:0] body, input int n);
    logic [15:0] crc;
    int          w;
    crc = crc_step(16'hFFFF, sa);
    put(sa);
    for (int i = 0; i < n; i++) begin
      crc = crc_step(crc, body[79-8*i -: 8]);
      put(body[79-8*i -: 8]);
    end
    put(crc[7:0]);
    put(crc[15:8]);
    @(posedge CLOCK);
    #1;
    RX_VALID = 1'b0;
    RX_DATA = ~RX_DATA;
    RX_FRAME_END = 1'b1;
    @(posedge CLOCK);
    #1;
    RX_FRAME_END = 1'b0;
    RX_DATA = ~RX_DATA;
    rsp.delete();
    w = 0;
    while (w < 40) begin
      @(posedge CLOCK);
      w++;
      if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
        rsp.push_back(TX_DATA);
        w = 0;
      end
    end
    crc = 16'hFFFF;
    foreach (rsp[k]) crc = crc_step(crc, rsp[k]);
    crc_ok = (crc === 16'h0000);
  endtask
endmodule

// *** tb/mbc_handler_tb.sv ***
// self-checking bench of the modbus handler, rows first, then hand tests
// assumes mbc_master as the link partner with a 20-cycle tick
module mbc_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] fc; logic [15:0] a; logic [15:0] d; logic [3:0] n; logic [47:0] e;
  } mbc_row_t;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] event_in = 8'h00;
  logic [7:0] tmo = 8'h00;
  logic       nv = 1'b0;
  logic [7:0] mod_addr = 8'h05;
  logic       rx_valid, rx_frame_end, tx_ready, tx_valid, lc, wd_en, status, led, l;
  logic [7:0] rx_data, tx_data;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         lc_cnt = 0;
  mbc_row_t   rows[14] = '{
    '{8'h04, 16'h0000, 16'h0002, 4'h6, 48'h0404_0000_0000},
    '{8'h01, 16'h010D, 16'h0001, 4'h3, 48'h0101_0000_0000},
    '{8'h03, 16'h01E8, 16'h0001, 4'h4, 48'h0302_0000_0000},
    '{8'h03, 16'h3038, 16'h0000, 4'h0, 48'h0000_0000_0000},
    '{8'h04, 16'h3038, 16'h0000, 4'h0, 48'h0000_0000_0000},
    '{8'h05, 16'h0107, 16'hFF00, 4'h5, 48'h0501_07FF_0000},
    '{8'h05, 16'h0104, 16'hFF00, 4'h5, 48'h0501_04FF_0000},
    '{8'h05, 16'h0104, 16'h0000, 4'h5, 48'h0501_0400_0000},
    '{8'h06, 16'h01E8, 16'h0001, 4'h2, 48'h8601_0000_0000},
    '{8'h04, 16'h0000, 16'h0009, 4'h2, 48'h8403_0000_0000},
    '{8'h05, 16'h0300, 16'hFF00, 4'h2, 48'h8502_0000_0000},
    '{8'h05, 16'h0200, 16'h1234, 4'h2, 48'h8503_0000_0000},
    '{8'h0F, 16'h0200, 16'h0001, 4'h2, 48'h8F03_0000_0000},
    '{8'h01, 16'h0020, 16'h0001, 4'h2, 48'h8102_0000_0000}};
  mbc_handler #(.TICK_CYCLES(20)) i_dut (.CLOCK(clock), .RST(rst), .MODULE_ADDR(mod_addr),
    .EVENT_IN(event_in), .TIMEOUT_VALUE(tmo), .NV_STATUS_IN(nv), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_FRAME_END(rx_frame_end), .TX_READY(tx_ready), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .LATCH_CLEAR(lc), .WATCHDOG_ENABLED(wd_en), .TIMEOUT_STATUS(status),
    .LED_FLASH(led));
  mbc_master i_mst (.CLOCK(clock), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_FRAME_END(rx_frame_end), .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data));
  always #12.5 clock = ~clock;
  always @(posedge clock) if (lc === 1'b1) lc_cnt++;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] n, input logic [47:0] e);
    i_mst.xfer(8'h05, {fc, a, d, 40'h0}, 5);
    chk("length", 16'(i_mst.rsp.size()), (n != 0) ? 16'(n) + 16'd3 : 16'd0);
    if (n != 0) begin
      chk("slave", {8'h00, i_mst.rsp[0]}, 16'h0005);
      for (int i = 0; i < n; i++)
        chk("byte", {8'h00, i_mst.rsp[i+1]}, {8'h00, e[47-8*i -: 8]});
      chk("crc", {15'h0, i_mst.crc_ok}, 16'h0001);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clock);
    chk("reset outputs", {12'h0, tx_valid, wd_en, status, led}, 16'h0000);
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    foreach (rows[i]) send(rows[i].fc, rows[i].a, rows[i].d, rows[i].n, rows[i].e);
    chk("latch pulses", 16'(lc_cnt), 16'h0001);
    $display("row tests done");
    i_mst.slow = 1'b1;
    @(posedge clock);
    #1 event_in = 8'h04;
    repeat (3) @(posedge clock);
    #1 event_in = 8'h01;
    @(posedge clock);
    #1 event_in = 8'h00;
    send(8'h04, 16'h0001, 16'h0002, 4'h6, 48'h0404_0000_0003);
    send(8'h04, 16'h0000, 16'h0001, 4'h4, 48'h0402_0001_0000);
    send(8'h05, 16'h0202, 16'hFF00, 4'h5, 48'h0502_02FF_0000);
    send(8'h04, 16'h0002, 16'h0001, 4'h4, 48'h0402_0000_0000);
    i_mst.xfer(8'h05, {8'h0F, 32'h0200_0008, 16'h0101, 24'h0}, 7);
    chk("multi echo", {8'h00, i_mst.rsp[5]}, 16'h0008);
    send(8'h04, 16'h0000, 16'h0001, 4'h4, 48'h0402_0000_0000);
    i_mst.xfer(8'h06, {8'h04, 32'h0000_0001, 40'h0}, 5);
    chk("foreign frame", 16'(i_mst.rsp.size()), 16'h0000);
    #1 mod_addr = 8'h00;
    i_mst.xfer(8'h00, {8'h04, 32'h0000_0001, 40'h0}, 5);
    chk("address zero", 16'(i_mst.rsp.size()), 16'h0000);
    #1 mod_addr = 8'h05;
    i_mst.slow = 1'b0;
    $display("counter tests done");
    #1 tmo = 8'h08;
    send(8'h03, 16'h01E8, 16'h0001, 4'h4, 48'h0302_0008_0000);
    send(8'h04, 16'h3038, 16'h0000, 4'h0, 48'h0);
    send(8'h05, 16'h0104, 16'hFF00, 4'h5, 48'h0501_04FF_0000);
    chk("enabled", {15'h0, wd_en}, 16'h0001);
    chk("status early", {15'h0, status}, 16'h0000);
    // eight 20-cycle ticks from enable, tick phase unknown
    repeat (130) @(posedge clock);
    chk("status late", {15'h0, status}, 16'h0001);
    l = led;
    repeat (20) @(posedge clock);
    chk("led toggles", {15'h0, led}, {15'h0, ~l});
    send(8'h05, 16'h0104, 16'h0000, 4'h5, 48'h0501_0400_0000);
    chk("status held", {15'h0, status}, 16'h0001);
    send(8'h01, 16'h010D, 16'h0001, 4'h3, 48'h0101_0100_0000);
    send(8'h05, 16'h010D, 16'hFF00, 4'h5, 48'h0501_0DFF_0000);
    chk("status cleared", {15'h0, status}, 16'h0000);
    $display("watchdog tests done");
    #1 rst = 1'b1;
    nv = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    repeat (2) @(posedge clock);
    chk("status restored", {15'h0, status}, 16'h0001);
    $display("restore test done");
    close_out;
  end
endmodule
